// File: design/irf_pkg.sv
/*
 Shared constants and carriers for the interrupt request flag block.
 Assumes a single 250 MHz core clock and a 16-bit special register port.
*/
package irf_pkg;
   // Register addresses on the special register port
   localparam logic [15:0] IRF_ADDR_G0_LOW = 16'hFFE0;
   localparam logic [15:0] IRF_ADDR_G0_HIGH = 16'hFFE1;
   localparam logic [15:0] IRF_ADDR_G1 = 16'hFFE2;
   localparam logic [7:0] IRF_FLAGS_RESET = 8'h00;
   localparam logic [7:0] IRF_CTRL_ONES_RESET = 8'hFF;
   localparam logic [2:0] IRF_EDGE_RESET = 3'h0;
   localparam int IRF_NSRC = 11;
   // Source indices, which are also the fixed default ranks (0 highest)
   localparam int IRF_SRC_LVI = 0;
   localparam int IRF_SRC_PIN0 = 1;
   localparam int IRF_SRC_PIN1 = 2;
   localparam int IRF_SRC_CMP = 3;
   localparam int IRF_SRC_SRX = 4;
   localparam int IRF_SRC_STX = 5;
   localparam int IRF_SRC_TH1 = 6;
   localparam int IRF_SRC_TCA = 7;
   localparam int IRF_SRC_TCB = 8;
   localparam int IRF_SRC_ADC = 9;
   localparam int IRF_SRC_T51 = 10;
   // Bit positions inside each register
   localparam int IRF_BIT_LVI = 0;
   localparam int IRF_BIT_PIN0 = 1;
   localparam int IRF_BIT_PIN1 = 2;
   localparam int IRF_BIT_CMP = 3;
   localparam int IRF_BIT_SRX = 0;
   localparam int IRF_BIT_STX = 1;
   localparam int IRF_BIT_TH1 = 3;
   localparam int IRF_BIT_TCA = 6;
   localparam int IRF_BIT_TCB = 7;
   localparam int IRF_BIT_ADC = 0;
   localparam int IRF_BIT_T51 = 3;
   localparam logic [3:0] IRF_NONE = 4'hF;

   typedef logic [IRF_NSRC-1:0] irf_vec_t;

   // One CPU access to the flag registers
   typedef struct packed {
      logic wr;
      logic bit_op;
      logic word_op;
      logic [15:0] addr;
      logic [2:0] bit_sel;
      logic [15:0] wdata;
   } irf_access_s;

   // Request presented to the CPU core
   typedef struct packed {
      logic valid;
      logic high_level;
      logic [3:0] src;
   } irf_req_s;
endpackage : irf_pkg

// File: design/irf_edge_detect.sv
/*
 Valid-edge detector for the external request inputs.
 Assumes inputs already synchronous to core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module irf_edge_detect
   import irf_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [2:0] level_i,
   input wire logic [2:0] rising_edge_enables_i,
   input wire logic [2:0] falling_edge_enables_i,
   output logic [2:0] edge_o
);
   logic [2:0] prev_reg;

   // Previous level, for edge comparison
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prev_reg <= IRF_EDGE_RESET;
      end else begin
         prev_reg <= level_i;
      end
   end

   // Enable pair 00 none, 01 fall, 10 rise, 11 both
   always_comb begin
      edge_o = (rising_edge_enables_i & level_i & ~prev_reg)
             | (falling_edge_enables_i & ~level_i & prev_reg);
   end
endmodule : irf_edge_detect
`default_nettype wire

// File: design/irf_arbiter.sv
/*
 Picks one unmasked pending source: high level first, then default rank.
 Assumes flags, masks and levels indexed by source rank.
*/
`timescale 1ns/1ps
`default_nettype none
module irf_arbiter
   import irf_pkg::*;
(
   input wire irf_vec_t pending_i,
   input wire irf_vec_t inhibit_i,
   input wire irf_vec_t level_sel_i,
   output irf_req_s req_o
);
   // Lowest index wins within the chosen level
   function automatic logic [3:0] first_set(input irf_vec_t v);
      logic [3:0] r;
      r = IRF_NONE;
      for (int i = IRF_NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction : first_set

   irf_vec_t hi_v;
   irf_vec_t lo_v;

   // Mask 0 allows service, level bit 0 selects high
   always_comb begin
      hi_v = pending_i & ~inhibit_i & ~level_sel_i;
      lo_v = pending_i & ~inhibit_i & level_sel_i;
      req_o.valid = |(hi_v | lo_v);
      req_o.high_level = |hi_v;
      req_o.src = (|hi_v) ? first_set(hi_v) : first_set(lo_v);
   end
endmodule : irf_arbiter
`default_nettype wire

// File: design/irf_request_flags.sv
/*
 Interrupt request flag registers, group 0 low/high and group 1, with
 source latching, CPU acknowledge clearing and request selection.
 Assumes source events are one-cycle pulses synchronous to core_clk_i
 and the CPU port performs one access per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module irf_request_flags
   import irf_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire irf_access_s acc_i,
   input wire logic low_voltage_event_i,
   input wire logic ext_pin0_i,
   input wire logic ext_pin1_i,
   input wire logic comparator_i,
   input wire logic [2:0] rising_edge_enables_i,
   input wire logic [2:0] falling_edge_enables_i,
   input wire logic serial_receive_event_i,
   input wire logic serial_transmit_event_i,
   input wire logic timer_h1_match_event_i,
   input wire logic timer_cmp_a_event_i,
   input wire logic timer_cmp_b_event_i,
   input wire logic conversion_end_event_i,
   input wire logic timer_51_match_event_i,
   input wire logic carrier_mode_i,
   input wire logic carrier_transfer_signal_i,
   input wire irf_vec_t service_inhibit_bit_i,
   input wire irf_vec_t level_select_bit_i,
   input wire logic ack_i,
   input wire logic [3:0] ack_src_i,
   output logic [15:0] rdata_o,
   output irf_req_s req_o,
   output logic [7:0] request_flags_group0_low_o,
   output logic [7:0] request_flags_group0_high_o,
   output logic [7:0] request_flags_group1_o
);
   logic [7:0] g0l_reg;
   logic [7:0] g0h_reg;
   logic [7:0] g1_reg;
   logic [2:0] pin_edge;
   irf_vec_t hw_set;
   irf_vec_t flags;
   irf_req_s arb_req;
   logic [7:0] set_g0l;
   logic [7:0] set_g0h;
   logic [7:0] set_g1;
   logic [7:0] clr_g0l;
   logic [7:0] clr_g0h;
   logic [7:0] clr_g1;

   // Turns an access into a write mask and data for one byte register
   function automatic logic [15:0] wr_lane(input irf_access_s a,
                                           input logic [15:0] reg_addr);
      logic [7:0] m;
      logic [7:0] d;
      m = 8'h00;
      d = 8'h00;
      if (a.wr && a.bit_op && a.addr == reg_addr) begin
         m = 8'h01 << a.bit_sel;
         d = a.wdata[7:0];
      end else if (a.wr && a.word_op && a.addr == IRF_ADDR_G0_LOW &&
                   reg_addr != IRF_ADDR_G1) begin
         m = 8'hFF;
         d = (reg_addr == IRF_ADDR_G0_LOW) ? a.wdata[7:0] : a.wdata[15:8];
      end else if (a.wr && !a.bit_op && !a.word_op &&
                   a.addr == reg_addr) begin
         m = 8'hFF;
         d = a.wdata[7:0];
      end
      return {m, d};
   endfunction : wr_lane

   irf_edge_detect u_edge (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .level_i({comparator_i, ext_pin1_i, ext_pin0_i}),
      .rising_edge_enables_i(rising_edge_enables_i),
      .falling_edge_enables_i(falling_edge_enables_i),
      .edge_o(pin_edge)
   );

   // Hardware set sources, indexed by default rank
   always_comb begin
      hw_set = '0;
      hw_set[IRF_SRC_LVI] = low_voltage_event_i;
      hw_set[IRF_SRC_PIN0] = pin_edge[0];
      hw_set[IRF_SRC_PIN1] = pin_edge[1];
      hw_set[IRF_SRC_CMP] = pin_edge[2];
      hw_set[IRF_SRC_SRX] = serial_receive_event_i;
      hw_set[IRF_SRC_STX] = serial_transmit_event_i;
      hw_set[IRF_SRC_TH1] = timer_h1_match_event_i;
      hw_set[IRF_SRC_TCA] = timer_cmp_a_event_i;
      hw_set[IRF_SRC_TCB] = timer_cmp_b_event_i;
      hw_set[IRF_SRC_ADC] = conversion_end_event_i;
      // Carrier mode takes the transfer instant instead
      hw_set[IRF_SRC_T51] = carrier_mode_i ? carrier_transfer_signal_i
                                           : timer_51_match_event_i;
   end

   // Scatter sources into register bit positions
   always_comb begin
      set_g0l = 8'h00;
      set_g0h = 8'h00;
      set_g1 = 8'h00;
      set_g0l[IRF_BIT_LVI] = hw_set[IRF_SRC_LVI];
      set_g0l[IRF_BIT_PIN0] = hw_set[IRF_SRC_PIN0];
      set_g0l[IRF_BIT_PIN1] = hw_set[IRF_SRC_PIN1];
      set_g0l[IRF_BIT_CMP] = hw_set[IRF_SRC_CMP];
      set_g0h[IRF_BIT_SRX] = hw_set[IRF_SRC_SRX];
      set_g0h[IRF_BIT_STX] = hw_set[IRF_SRC_STX];
      set_g0h[IRF_BIT_TH1] = hw_set[IRF_SRC_TH1];
      set_g0h[IRF_BIT_TCA] = hw_set[IRF_SRC_TCA];
      set_g0h[IRF_BIT_TCB] = hw_set[IRF_SRC_TCB];
      set_g1[IRF_BIT_ADC] = hw_set[IRF_SRC_ADC];
      set_g1[IRF_BIT_T51] = hw_set[IRF_SRC_T51];
   end

   // Acknowledge clears the accepted source's flag
   always_comb begin
      clr_g0l = 8'h00;
      clr_g0h = 8'h00;
      clr_g1 = 8'h00;
      if (ack_i) begin
         case (ack_src_i)
            4'(IRF_SRC_LVI): clr_g0l[IRF_BIT_LVI] = 1'b1;
            4'(IRF_SRC_PIN0): clr_g0l[IRF_BIT_PIN0] = 1'b1;
            4'(IRF_SRC_PIN1): clr_g0l[IRF_BIT_PIN1] = 1'b1;
            4'(IRF_SRC_CMP): clr_g0l[IRF_BIT_CMP] = 1'b1;
            4'(IRF_SRC_SRX): clr_g0h[IRF_BIT_SRX] = 1'b1;
            4'(IRF_SRC_STX): clr_g0h[IRF_BIT_STX] = 1'b1;
            4'(IRF_SRC_TH1): clr_g0h[IRF_BIT_TH1] = 1'b1;
            4'(IRF_SRC_TCA): clr_g0h[IRF_BIT_TCA] = 1'b1;
            4'(IRF_SRC_TCB): clr_g0h[IRF_BIT_TCB] = 1'b1;
            4'(IRF_SRC_ADC): clr_g1[IRF_BIT_ADC] = 1'b1;
            4'(IRF_SRC_T51): clr_g1[IRF_BIT_T51] = 1'b1;
            default: clr_g0l = 8'h00;
         endcase
      end
   end

   // Software write first, then ack clear, then hardware set on top,
   // so a same-cycle event is never lost
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         g0l_reg <= IRF_FLAGS_RESET;
         g0h_reg <= IRF_FLAGS_RESET;
         g1_reg <= IRF_FLAGS_RESET;
      end else begin
         g0l_reg <= upd(g0l_reg, wr_lane(acc_i, IRF_ADDR_G0_LOW),
                        clr_g0l, set_g0l);
         g0h_reg <= upd(g0h_reg, wr_lane(acc_i, IRF_ADDR_G0_HIGH),
                        clr_g0h, set_g0h);
         g1_reg <= upd(g1_reg, wr_lane(acc_i, IRF_ADDR_G1),
                       clr_g1, set_g1);
      end
   end

   function automatic logic [7:0] upd(input logic [7:0] cur,
                                      input logic [15:0] md,
                                      input logic [7:0] clr,
                                      input logic [7:0] set);
      logic [7:0] v;
      v = (cur & ~md[15:8]) | (md[7:0] & md[15:8]);
      return (v & ~clr) | set;
   endfunction : upd

   // Pending vector by rank; a 1 means a request is pending
   always_comb begin
      flags = '0;
      flags[IRF_SRC_LVI] = g0l_reg[IRF_BIT_LVI];
      flags[IRF_SRC_PIN0] = g0l_reg[IRF_BIT_PIN0];
      flags[IRF_SRC_PIN1] = g0l_reg[IRF_BIT_PIN1];
      flags[IRF_SRC_CMP] = g0l_reg[IRF_BIT_CMP];
      flags[IRF_SRC_SRX] = g0h_reg[IRF_BIT_SRX];
      flags[IRF_SRC_STX] = g0h_reg[IRF_BIT_STX];
      flags[IRF_SRC_TH1] = g0h_reg[IRF_BIT_TH1];
      flags[IRF_SRC_TCA] = g0h_reg[IRF_BIT_TCA];
      flags[IRF_SRC_TCB] = g0h_reg[IRF_BIT_TCB];
      flags[IRF_SRC_ADC] = g1_reg[IRF_BIT_ADC];
      flags[IRF_SRC_T51] = g1_reg[IRF_BIT_T51];
   end

   irf_arbiter u_arb (
      .pending_i(flags),
      .inhibit_i(service_inhibit_bit_i),
      .level_sel_i(level_select_bit_i),
      .req_o(arb_req)
   );

   // Request is registered; an ack pulse drops it one cycle later
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         req_o <= '0;
      end else begin
         req_o <= arb_req;
      end
   end

   // Registered read data; word read pairs high over low
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
      end else if (acc_i.word_op && acc_i.addr == IRF_ADDR_G0_LOW) begin
         rdata_o <= {g0h_reg, g0l_reg};
      end else begin
         case (acc_i.addr)
            IRF_ADDR_G0_LOW: rdata_o <= {8'h00, g0l_reg};
            IRF_ADDR_G0_HIGH: rdata_o <= {8'h00, g0h_reg};
            IRF_ADDR_G1: rdata_o <= {8'h00, g1_reg};
            default: rdata_o <= 16'h0000;
         endcase
      end
   end

   // Mirrors of the flag registers for the neighbouring logic
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         request_flags_group0_low_o <= IRF_FLAGS_RESET;
         request_flags_group0_high_o <= IRF_FLAGS_RESET;
         request_flags_group1_o <= IRF_FLAGS_RESET;
      end else begin
         request_flags_group0_low_o <= g0l_reg;
         request_flags_group0_high_o <= g0h_reg;
         request_flags_group1_o <= g1_reg;
      end
   end

   // Checks
   property p_hw_set_wins;
      @(posedge core_clk_i) disable iff (rst_i)
      (serial_receive_event_i && acc_i.wr && !acc_i.word_op &&
       acc_i.addr == IRF_ADDR_G0_HIGH) |=> g0h_reg[IRF_BIT_SRX];
   endproperty
   a_hw_set_wins: assert property (p_hw_set_wins)
      else $error("same-cycle set lost to clear");

   property p_ack_clears;
      @(posedge core_clk_i) disable iff (rst_i)
      (ack_i && ack_src_i == 4'(IRF_SRC_ADC) && !conversion_end_event_i &&
       !acc_i.wr) |=> !g1_reg[IRF_BIT_ADC];
   endproperty
   a_ack_clears: assert property (p_ack_clears)
      else $error("ack did not clear flag");

   property p_byte_write;
      @(posedge core_clk_i) disable iff (rst_i)
      (acc_i.wr && !acc_i.bit_op && !acc_i.word_op &&
       acc_i.addr == IRF_ADDR_G1 && !ack_i && set_g1 == 8'h00)
      |=> g1_reg == $past(acc_i.wdata[7:0]);
   endproperty
   a_byte_write: assert property (p_byte_write)
      else $error("byte write not stored");

   sequence s_bit_write_g0l;
      acc_i.wr && acc_i.bit_op && acc_i.addr == IRF_ADDR_G0_LOW && !ack_i
      && set_g0l == 8'h00;
   endsequence
   property p_bit_only;
      @(posedge core_clk_i) disable iff (rst_i)
      s_bit_write_g0l |=> ((g0l_reg ^ $past(g0l_reg)) &
                           ~(8'h01 << $past(acc_i.bit_sel))) == 8'h00;
   endproperty
   a_bit_only: assert property (p_bit_only)
      else $error("bit write touched other flags");

   property p_word_read;
      @(posedge core_clk_i) disable iff (rst_i)
      (acc_i.word_op && acc_i.addr == IRF_ADDR_G0_LOW)
      |=> rdata_o == {$past(g0h_reg), $past(g0l_reg)};
   endproperty
   a_word_read: assert property (p_word_read)
      else $error("word read mispaired");

   property p_carrier;
      @(posedge core_clk_i) disable iff (rst_i)
      (carrier_mode_i && carrier_transfer_signal_i) |=> g1_reg[IRF_BIT_T51];
   endproperty
   a_carrier: assert property (p_carrier)
      else $error("carrier transfer did not set flag");

   property p_masked_none;
      @(posedge core_clk_i) disable iff (rst_i)
      (&service_inhibit_bit_i) |=> !req_o.valid;
   endproperty
   a_masked_none: assert property (p_masked_none)
      else $error("masked source requested");

   property p_rank;
      @(posedge core_clk_i) disable iff (rst_i)
      (flags[IRF_SRC_LVI] && !service_inhibit_bit_i[IRF_SRC_LVI] &&
       !level_select_bit_i[IRF_SRC_LVI]) |=> req_o.src == 4'(IRF_SRC_LVI);
   endproperty
   a_rank: assert property (p_rank)
      else $error("top-rank high source not selected");

   property p_reset_zero;
      @(posedge core_clk_i) $fell(rst_i) |-> g0l_reg == 8'h00 &&
         g0h_reg == 8'h00 && g1_reg == 8'h00;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("flags not zero after reset");
endmodule : irf_request_flags
`default_nettype wire

// File: sim/irf_cpu_model.sv
/*
 Behavioural CPU core that accepts requests from the flag block.
 Assumes req_i is registered in the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module irf_cpu_model
   import irf_pkg::*;
#(
   parameter int SLOW_CYCLES = 3
)
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire irf_req_s req_i,
   input wire logic enable_i,
   input wire logic slow_i,
   output logic ack_o,
   output logic [3:0] ack_src_o
);
   // One acceptance at a time; waits out the registered request path
   initial begin
      ack_o = 1'b0;
      ack_src_o = 4'h0;
      forever begin
         @(negedge core_clk_i);
         if (!rst_i && enable_i && req_i.valid === 1'b1) begin
            if (slow_i) begin
               repeat (SLOW_CYCLES) @(negedge core_clk_i);
            end
            ack_o = 1'b1;
            ack_src_o = req_i.src;
            @(negedge core_clk_i);
            ack_o = 1'b0;
            ack_src_o = ~ack_src_o; // Released: never the last value
            repeat (3) @(negedge core_clk_i);
         end
      end
   end
endmodule : irf_cpu_model
`default_nettype wire

// File: sim/irf_tb.sv
/*
 Self-checking bench for the request flag block, one task a scenario.
 Assumes the package, design and CPU model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
   import irf_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmode = 1'b0;
   logic ctx = 1'b0;
   logic en = 1'b0;
   logic slow = 1'b0;
   logic ack;
   logic [3:0] ack_src;
   logic [7:0] ev = 8'h00;
   logic [2:0] pins = 3'h0;
   logic [2:0] rise = 3'h0;
   logic [2:0] fall = 3'h0;
   irf_vec_t inh = '1;
   irf_vec_t lvl = '1;
   irf_access_s acc_s = '0;
   logic [15:0] rdata;
   irf_req_s req;
   logic [7:0] g0l, g0h, g1;
   logic [23:0] fl;
   logic [15:0] q;
   logic [3:0] log_q[$];
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   // Flag bit of each event input within {group1, group0 high, group0 low}
   localparam int EVB[8] = '{IRF_BIT_LVI, 8 + IRF_BIT_SRX, 8 + IRF_BIT_STX,
      8 + IRF_BIT_TH1, 8 + IRF_BIT_TCA, 8 + IRF_BIT_TCB, 16 + IRF_BIT_ADC,
      16 + IRF_BIT_T51};
   assign fl = {g1, g0h, g0l};

   irf_request_flags u_irf_request_flags (.core_clk_i(clk), .rst_i(rst),
      .acc_i(acc_s), .low_voltage_event_i(ev[0]), .ext_pin0_i(pins[0]),
      .ext_pin1_i(pins[1]), .comparator_i(pins[2]),
      .rising_edge_enables_i(rise), .falling_edge_enables_i(fall),
      .serial_receive_event_i(ev[1]), .serial_transmit_event_i(ev[2]),
      .timer_h1_match_event_i(ev[3]), .timer_cmp_a_event_i(ev[4]),
      .timer_cmp_b_event_i(ev[5]), .conversion_end_event_i(ev[6]),
      .timer_51_match_event_i(ev[7]), .carrier_mode_i(cmode),
      .carrier_transfer_signal_i(ctx), .service_inhibit_bit_i(inh),
      .level_select_bit_i(lvl), .ack_i(ack), .ack_src_i(ack_src),
      .rdata_o(rdata), .req_o(req), .request_flags_group0_low_o(g0l),
      .request_flags_group0_high_o(g0h), .request_flags_group1_o(g1));
   irf_cpu_model u_irf_cpu_model (.core_clk_i(clk), .rst_i(rst),
      .req_i(req), .enable_i(en), .slow_i(slow), .ack_o(ack),
      .ack_src_o(ack_src));

   // Clock, acceptance log and hang guard
   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (ack === 1'b1) log_q.push_back(ack_src);
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim

   // One access for one cycle; a read returns the registered data
   task automatic acc(input logic w, b, wd, input logic [15:0] a,
      input logic [2:0] s, input logic [15:0] d);
      @(negedge clk);
      acc_s = '{w, b, wd, a, s, d};
      @(negedge clk);
      q = rdata;
      acc_s = '0;
   endtask : acc

   task automatic settle();
      repeat (3) @(negedge clk);
   endtask : settle

   task automatic clr_all();
      acc(1, 0, 1, IRF_ADDR_G0_LOW, 0, 16'h0000);
      acc(1, 0, 0, IRF_ADDR_G1, 0, 16'h0000);
      settle();
   endtask : clr_all

   task automatic do_reset();
      @(negedge clk);
      rst = 1'b1;
      repeat (8) @(negedge clk);
      `CHK(fl, 24'h000000)
      rst = 1'b0;
   endtask : do_reset

   // Byte, bit and word accesses, unmapped and misplaced ones ignored
   task automatic t_regs();
      acc(0, 0, 0, IRF_ADDR_G1, 0, 16'h0000);
      `CHK(q[7:0], IRF_FLAGS_RESET)
      acc(1, 0, 0, IRF_ADDR_G0_HIGH, 0, 16'h00CB);
      acc(1, 0, 1, IRF_ADDR_G1, 0, 16'h0909); // Word op elsewhere: ignored
      acc(1, 0, 0, 16'hFFE3, 0, 16'h0009);
      settle();
      `CHK(fl, 24'h00CB00)
      acc(1, 0, 1, IRF_ADDR_G0_LOW, 0, 16'h4A05);
      acc(0, 0, 1, IRF_ADDR_G0_LOW, 0, 16'h0000);
      `CHK(q, 16'h4A05)
      acc(1, 1, 0, IRF_ADDR_G0_LOW, 2, 16'h0000);
      acc(1, 1, 0, IRF_ADDR_G1, IRF_BIT_T51, 16'h0008); // Value at bit_sel
      acc(0, 0, 0, 16'hFFE3, 0, 16'h0000);
      `CHK(q, 16'h0000)
      settle();
      `CHK(fl, 24'h084A01)
   endtask : t_regs

   // Each of the eight ev event inputs sets only its own flag
   task automatic t_events();
      for (int i = 0; i < 8; i++) begin
         clr_all();
         ev[i] = 1'b1;
         @(negedge clk);
         ev[i] = 1'b0;
         settle();
         `CHK(fl, 24'h000001 << EVB[i])
      end
   endtask : t_events

   // All four edge selections on each external input
   task automatic t_edges();
      for (int p = 0; p < 3; p++) begin
         for (int m = 0; m < 4; m++) begin
            rise = 3'(m[1]) << p;
            fall = 3'(m[0]) << p;
            clr_all();
            pins[p] = 1'b1;
            settle();
            `CHK(fl[p + 1], 1'(m[1]))
            clr_all();
            pins[p] = 1'b0;
            settle();
            `CHK(fl[p + 1], 1'(m[0]))
         end
      end
      rise = 3'h0;
      fall = 3'h0;
   endtask : t_edges

   // Carrier transfer sets the timer 51 flag only in carrier mode
   task automatic t_carrier();
      for (int m = 0; m < 2; m++) begin
         cmode = 1'(m);
         clr_all();
         ctx = 1'b1;
         @(negedge clk);
         ctx = 1'b0;
         settle();
         `CHK(g1[IRF_BIT_T51], 1'(m))
      end
      cmode = 1'b0;
   endtask : t_carrier

   // A request in the same cycle as a software clear must survive
   task automatic t_race();
      acc(1, 1, 0, IRF_ADDR_G0_HIGH, IRF_BIT_SRX, 16'h0001);
      @(negedge clk);
      acc_s = '{1'b1, 1'b1, 1'b0, IRF_ADDR_G0_HIGH, 3'h0, 16'h0000};
      ev[1] = 1'b1;
      @(negedge clk);
      acc_s = '0;
      ev[1] = 1'b0;
      settle();
      `CHK(g0h[IRF_BIT_SRX], 1'b1)
      acc(1, 1, 0, IRF_ADDR_G0_HIGH, IRF_BIT_SRX, 16'h0000);
      settle();
      `CHK(g0h[IRF_BIT_SRX], 1'b0)
   endtask : t_race

   // Fixed rank decides between two high-level requests shown to the core
   task automatic t_rank();
      inh = '0;
      lvl = '1;
      lvl[IRF_SRC_TCB] = 1'b0;
      clr_all();
      acc(1, 1, 0, IRF_ADDR_G0_HIGH, IRF_BIT_TCB, 16'h0080);
      settle();
      `CHK(req, {2'h3, 4'(IRF_SRC_TCB)})
      lvl[IRF_SRC_LVI] = 1'b0;
      acc(1, 1, 0, IRF_ADDR_G0_LOW, IRF_BIT_LVI, 16'h0001);
      settle();
      `CHK(req, {2'h3, 4'(IRF_SRC_LVI)})
      inh = '1;
      lvl = '1;
   endtask : t_rank

   // Service order by level and rank; acceptance clears the flag
   task automatic t_service(input logic sl);
      clr_all();
      acc(1, 1, 0, IRF_ADDR_G0_HIGH, IRF_BIT_SRX, 16'h0001);
      acc(1, 1, 0, IRF_ADDR_G1, IRF_BIT_ADC, 16'h0001);
      acc(1, 1, 0, IRF_ADDR_G0_LOW, IRF_BIT_LVI, 16'h0001);
      log_q.delete();
      slow = sl;
      en = 1'b1;
      repeat (40) @(negedge clk);
      en = 1'b0;
      `CHK(log_q.size(), 2)
      `CHK(log_q[0], 4'(sl ? IRF_SRC_SRX : IRF_SRC_ADC))
      `CHK(fl, 24'h000001)
   endtask : t_service

   initial begin
      do_reset();
      t_regs();
      t_events();
      t_edges();
      t_carrier();
      t_race();
      t_rank();
      inh = '1;
      inh[IRF_SRC_SRX] = 1'b0;
      inh[IRF_SRC_ADC] = 1'b0;
      lvl[IRF_SRC_ADC] = 1'b0;
      t_service(1'b0);
      lvl = '1;
      t_service(1'b1);
      do_reset();
      end_sim();
   end
endmodule : tb
`default_nettype wire
